//--- hdl/sstx_pkg.sv
// package: register map, field layout and constants of the slave transmit block
package sstx_pkg;
   localparam logic [11:0] SSTX_OFF_TX_ADDR   = 12'h544;
   localparam logic [11:0] SSTX_OFF_TX_SIZE   = 12'h548;
   localparam logic [11:0] SSTX_OFF_TX_SENT   = 12'h54C;
   localparam logic [11:0] SSTX_OFF_LIST      = 12'h550;
   localparam logic [11:0] SSTX_OFF_CONFIG    = 12'h554;
   localparam logic [11:0] SSTX_OFF_IGN_CHAR  = 12'h55C;
   localparam logic [11:0] SSTX_OFF_OVR_CHAR  = 12'h5C0;
   localparam logic [11:0] SSTX_OFF_CTRL      = 12'h600;
   localparam logic [11:0] SSTX_OFF_STATUS    = 12'h604;
   localparam int          SSTX_CNT_W         = 13;
   localparam logic [12:0] SSTX_CNT_MAX       = 13'h1FFF;
   localparam int          SSTX_CFG_ORDER_BIT = 0;
   localparam int          SSTX_CFG_CPHA_BIT  = 1;
   localparam int          SSTX_CFG_CPOL_BIT  = 2;
   localparam int          SSTX_CTRL_GRANT    = 0;
   localparam logic [31:0] SSTX_RST_WORD      = 32'h0000_0000;
   localparam logic [7:0]  SSTX_RST_CHAR      = 8'h00;
   typedef enum logic [3:0] {
      SSTX_IDLE  = 4'b0001,
      SSTX_FETCH = 4'b0010,
      SSTX_WAIT  = 4'b0100,
      SSTX_SHIFT = 4'b1000
   } sstx_state_e;
endpackage : sstx_pkg

//--- hdl/sstx_fetch_if.sv
// interface: byte fetch request between the transmit core and its memory reader
`timescale 1ns/1ps
`default_nettype none
interface sstx_fetch_if;
   logic        req;
   logic [31:0] addr;
   logic        ack;
   logic [7:0]  data;
   modport core (output req, output addr, input ack, input data);
   modport rdr  (input req, input addr, output ack, output data);
endinterface : sstx_fetch_if
`default_nettype wire

//--- hdl/sstx_dma_reader.sv
// module: single-byte memory reader that fetches transmit bytes over a word port
`timescale 1ns/1ps
`default_nettype none
module sstx_dma_reader
   import sstx_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    rst,
   sstx_fetch_if.rdr    fif,
   output logic         mem_req,
   output logic [31:0]  mem_addr,
   input  wire logic    mem_ack,
   input  wire logic [31:0] mem_rdata
);
   logic [1:0] lane_q;
   logic       busy_q;
   logic       ack_q;
   logic [7:0] data_q;
   logic [31:0] addr_q;

   assign mem_req  = busy_q;
   assign mem_addr = addr_q;
   assign fif.ack  = ack_q;
   assign fif.data = data_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_q <= 1'b0;
         ack_q  <= 1'b0;
         data_q <= 8'h00;
         lane_q <= 2'b00;
         addr_q <= 32'h0000_0000;
      end else begin
         ack_q <= 1'b0;
         if (!busy_q && fif.req && !ack_q) begin
            busy_q <= 1'b1;
            lane_q <= fif.addr[1:0];
            addr_q <= {fif.addr[31:2], 2'b00};
         end else if (busy_q && mem_ack) begin
            busy_q <= 1'b0;
            ack_q  <= 1'b1;
            data_q <= mem_rdata[8*lane_q +: 8];
         end
      end
   end
endmodule : sstx_dma_reader
`default_nettype wire

//--- hdl/sstx_core.sv
// top: slave serial transmit path with buffer fetch, format config and registers
//
// Behaviour
// - transmit bytes fetched from memory starting at buffer address register
// - buffer size register limits bytes fetched, legal range 1 to 0x1FFF
// - sent count register updated with bytes sent after each granted frame
// - bit order 0 sends high bit first, 1 sends low bit first
// - phase 0 samples leading edge, shifts trailing; phase 1 reversed
// - polarity 0 clock idles low, 1 clock idles high; both agree
// - frame without granted buffer sends the ignored-transfer fill character
// - bytes beyond buffer size send the overrun fill character
`timescale 1ns/1ps
`default_nettype none
module sstx_core
   import sstx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   output logic             mem_req,
   output logic      [31:0] mem_addr,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        sck,
   input  wire logic        csn,
   output logic             miso_o,
   output logic             miso_oe_n,
   output logic             frame_done
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0] tx_buffer_address_q;
   logic [12:0] tx_buffer_size_q;
   logic [12:0] tx_sent_count_q;
   logic        list_kind_q;
   logic [2:0]  cfg_q;
   logic [7:0]  ignored_transfer_fill_char_q;
   logic [7:0]  overrun_fill_char_q;
   logic        grant_q;
   logic [31:0] rd_d;
   logic        wr_stb;
   logic [11:0] off;

   // serial state
   sstx_state_e state_q;
   logic        sck_q;
   logic        csn_q;
   logic [7:0]  shreg_q;
   logic [2:0]  bitcnt_q;
   logic [12:0] fetched_q;
   logic [12:0] sent_q;
   logic        frame_grant_q;
   logic [7:0]  next_byte_q;
   logic        next_ok_q;
   logic        lead_edge;
   logic        trail_edge;
   logic        shift_edge;
   logic        sample_edge;
   logic        cs_fall;
   logic        cs_rise;
   logic [7:0]  fill_char;
   logic        want_fetch;
   logic        cur_buf_q;

   sstx_fetch_if fif ();

   assign off    = wb_adr_i[11:0];
   // write lands at the edge where the master samples ack high
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   // ----------------------------------------------------------------
   // wishbone slave: one wait cycle, ack one cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= SSTX_RST_WORD;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= rd_d;
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      case (off)
         SSTX_OFF_TX_ADDR:  rd_d = tx_buffer_address_q;
         SSTX_OFF_TX_SIZE:  rd_d = {19'h0, tx_buffer_size_q};
         SSTX_OFF_TX_SENT:  rd_d = {19'h0, tx_sent_count_q};
         SSTX_OFF_LIST:     rd_d = {31'h0, list_kind_q};
         SSTX_OFF_CONFIG:   rd_d = {29'h0, cfg_q};
         SSTX_OFF_IGN_CHAR: rd_d = {24'h0, ignored_transfer_fill_char_q};
         SSTX_OFF_OVR_CHAR: rd_d = {24'h0, overrun_fill_char_q};
         SSTX_OFF_CTRL:     rd_d = {31'h0, grant_q};
         SSTX_OFF_STATUS:   rd_d = {27'h0, state_q, !csn_q};
         default:           rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tx_buffer_address_q          <= SSTX_RST_WORD;
         tx_buffer_size_q             <= 13'h0000;
         list_kind_q                  <= 1'b0;
         cfg_q                        <= 3'b000;
         ignored_transfer_fill_char_q <= SSTX_RST_CHAR;
         overrun_fill_char_q          <= SSTX_RST_CHAR;
      end else if (wr_stb) begin
         case (off)
            SSTX_OFF_TX_ADDR: begin
               for (int b = 0; b < 4; b++) begin
                  if (wb_sel_i[b]) begin
                     tx_buffer_address_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
                  end
               end
            end
            SSTX_OFF_TX_SIZE: begin
               if (wb_sel_i[0]) begin
                  tx_buffer_size_q[7:0] <= wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  tx_buffer_size_q[12:8] <= wb_dat_i[12:8];
               end
            end
            SSTX_OFF_LIST: begin
               if (wb_sel_i[0]) begin
                  list_kind_q <= wb_dat_i[0];
               end
            end
            SSTX_OFF_CONFIG: begin
               if (wb_sel_i[0]) begin
                  cfg_q <= wb_dat_i[2:0];
               end
            end
            SSTX_OFF_IGN_CHAR: begin
               if (wb_sel_i[0]) begin
                  ignored_transfer_fill_char_q <= wb_dat_i[7:0];
               end
            end
            SSTX_OFF_OVR_CHAR: begin
               if (wb_sel_i[0]) begin
                  overrun_fill_char_q <= wb_dat_i[7:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // grant: set by software, released by hardware at frame end (set wins)
   always_ff @(posedge clk) begin
      if (rst) begin
         grant_q <= 1'b0;
      end else if (wr_stb && off == SSTX_OFF_CTRL && wb_sel_i[0]) begin
         grant_q <= wb_dat_i[SSTX_CTRL_GRANT];
      end else if (cs_rise && frame_grant_q) begin
         grant_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // serial clock edges
   // ----------------------------------------------------------------
   // polarity picks leading edge
   assign lead_edge  = !csn_q && (sck != sck_q) && (sck != cfg_q[SSTX_CFG_CPOL_BIT]);
   assign trail_edge = !csn_q && (sck != sck_q) && (sck == cfg_q[SSTX_CFG_CPOL_BIT]);
   assign shift_edge  = cfg_q[SSTX_CFG_CPHA_BIT] ? lead_edge : trail_edge;
   assign sample_edge = cfg_q[SSTX_CFG_CPHA_BIT] ? trail_edge : lead_edge;
   assign cs_fall = csn_q && !csn;
   assign cs_rise = !csn_q && csn;

   assign fill_char = frame_grant_q ? overrun_fill_char_q : ignored_transfer_fill_char_q;
   assign want_fetch = frame_grant_q && (fetched_q < tx_buffer_size_q) && !next_ok_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         sck_q <= 1'b0;
         csn_q <= 1'b1;
      end else begin
         sck_q <= sck;
         csn_q <= csn;
      end
   end

   // ----------------------------------------------------------------
   // fetch state machine
   // ----------------------------------------------------------------
   // fetch from buffer address
   assign fif.req  = (state_q == SSTX_WAIT);
   assign fif.addr = tx_buffer_address_q + {19'h0, fetched_q};

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q   <= SSTX_IDLE;
         fetched_q <= 13'h0000;
         next_ok_q <= 1'b0;
         next_byte_q <= 8'h00;
         frame_grant_q <= 1'b0;
      end else begin
         case (state_q)
            SSTX_IDLE: begin
               if (cs_fall) begin
                  frame_grant_q <= grant_q;
                  fetched_q     <= 13'h0000;
                  next_ok_q     <= 1'b0;
                  state_q       <= SSTX_FETCH;
               end
            end
            SSTX_FETCH: begin
               // a frame cut during a fetch still returns to idle
               if (csn) begin
                  state_q <= SSTX_IDLE;
               end else if (want_fetch) begin
                  state_q <= SSTX_WAIT;
               end
            end
            SSTX_WAIT: begin
               if (fif.ack) begin
                  next_byte_q <= fif.data;
                  next_ok_q   <= 1'b1;
                  fetched_q   <= fetched_q + 13'h0001;
                  state_q     <= csn ? SSTX_IDLE : SSTX_FETCH;
               end
            end
            default: state_q <= SSTX_IDLE;
         endcase
         if (state_q != SSTX_WAIT && shift_edge && bitcnt_q == 3'd7) begin
            next_ok_q <= 1'b0;
         end
         // grant of a frame ends with the frame
         if (cs_rise) begin
            frame_grant_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // shifter
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         shreg_q    <= 8'h00;
         bitcnt_q   <= 3'd0;
         sent_q     <= 13'h0000;
         miso_o     <= 1'b0;
         miso_oe_n  <= 1'b1;
         cur_buf_q  <= 1'b0;
      end else if (cs_fall) begin
         bitcnt_q  <= 3'd0;
         sent_q    <= 13'h0000;
         cur_buf_q <= 1'b0;
         miso_oe_n <= 1'b0;
         shreg_q   <= grant_q ? overrun_fill_char_q : ignored_transfer_fill_char_q;
         miso_o    <= 1'b0;
      end else if (cs_rise) begin
         miso_oe_n <= 1'b1;
      end else if (shift_edge) begin
         miso_o   <= cfg_q[SSTX_CFG_ORDER_BIT] ? shreg_q[0] : shreg_q[7];
         shreg_q  <= cfg_q[SSTX_CFG_ORDER_BIT] ? {1'b0, shreg_q[7:1]} : {shreg_q[6:0], 1'b0};
         bitcnt_q <= bitcnt_q + 3'd1;
         // a buffer byte counts once its first bit is out
         if (bitcnt_q == 3'd0 && cur_buf_q && sent_q != SSTX_CNT_MAX) begin
            sent_q <= sent_q + 13'h0001;
         end
         if (bitcnt_q == 3'd7) begin
            shreg_q   <= next_ok_q ? next_byte_q : fill_char;
            cur_buf_q <= frame_grant_q && next_ok_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tx_sent_count_q <= 13'h0000;
         frame_done      <= 1'b0;
      end else begin
         frame_done <= cs_rise && frame_grant_q;
         if (cs_rise && frame_grant_q) begin
            tx_sent_count_q <= sent_q;
         end
      end
   end

   sstx_dma_reader u_rdr (
      .clk       (clk),
      .rst       (rst),
      .fif       (fif),
      .mem_req   (mem_req),
      .mem_addr  (mem_addr),
      .mem_ack   (mem_ack),
      .mem_rdata (mem_rdata)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_ACK_ONE: assert property (@(posedge clk) disable iff (rst)
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   AST_SENT_UPD: assert property (@(posedge clk) disable iff (rst)
      (cs_rise && frame_grant_q) |=> tx_sent_count_q == $past(sent_q))
      else $error("sent count not updated");
   AST_FETCH_LIM: assert property (@(posedge clk) disable iff (rst)
      fetched_q <= tx_buffer_size_q || !frame_grant_q) else $error("over fetch");
   AST_ADDR: assert property (@(posedge clk) disable iff (rst)
      fif.ack |=> fif.addr == $past(fif.addr) + 32'h0000_0001)
      else $error("fetch address wrong");
   AST_IGN: assert property (@(posedge clk) disable iff (rst)
      (cs_fall && !grant_q) |=> shreg_q == ignored_transfer_fill_char_q)
      else $error("ignored fill missing");
   AST_MSB: assert property (@(posedge clk) disable iff (rst)
      (shift_edge && !cs_fall && !cs_rise && !cfg_q[SSTX_CFG_ORDER_BIT])
      |=> miso_o == $past(shreg_q[7])) else $error("msb order wrong");
   AST_LSB: assert property (@(posedge clk) disable iff (rst)
      (shift_edge && !cs_fall && !cs_rise && cfg_q[SSTX_CFG_ORDER_BIT])
      |=> miso_o == $past(shreg_q[0])) else $error("lsb order wrong");
   AST_EDGE: assert property (@(posedge clk) disable iff (rst)
      sample_edge |=> $stable(miso_o)) else $error("miso moved on sample edge");
   AST_OVR: assert property (@(posedge clk) disable iff (rst)
      (shift_edge && bitcnt_q == 3'd7 && !next_ok_q && frame_grant_q && !cs_rise
       && !cs_fall) |=> shreg_q == overrun_fill_char_q) else $error("overrun fill");
   AST_OE: assert property (@(posedge clk) disable iff (rst)
      cs_rise |=> miso_oe_n) else $error("miso not released");
   COV_FRAME: cover property (@(posedge clk) disable iff (rst) cs_rise && frame_grant_q);
   COV_IGN:   cover property (@(posedge clk) disable iff (rst) cs_fall && !grant_q);
   COV_FETCH: cover property (@(posedge clk) disable iff (rst) fif.ack);
endmodule : sstx_core
`default_nettype wire

//--- tb/sstx_spi_master.sv
// partner: serial master model that frames bytes and samples the slave output
`timescale 1ns/1ps
`default_nettype none
module sstx_spi_master (
   input  wire logic clk,
   input  wire logic cpol,
   input  wire logic cpha,
   output logic      sck,
   output logic      csn,
   input  wire logic miso_o,
   input  wire logic miso_oe_n
);
   localparam int HALF = 16;
   logic [7:0] rx_q[$];
   int         oe_err = 0;
   initial begin
      sck = 1'b0;
      csn = 1'b1;
   end
   // ----------------------------------------
   // frame of nb bytes, clock still outside
   // ----------------------------------------
   task automatic frame(input int nb);
      logic [7:0] b;
      sck <= cpol;
      repeat (4) @(posedge clk);
      csn <= 1'b0;
      repeat (HALF) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         for (int e = 0; e < 16; e++) begin
            sck <= ~sck;
            repeat (HALF - 2) @(posedge clk);
            if (e % 2 != int'(cpha)) begin
               b = {b[6:0], miso_o};
               if (miso_oe_n !== 1'b0)
                  oe_err++;
            end
            repeat (2) @(posedge clk);
         end
         rx_q.push_back(b);
      end
      repeat (HALF) @(posedge clk);
      csn <= 1'b1;
      repeat (HALF) @(posedge clk);
   endtask
endmodule // sstx_spi_master
`default_nettype wire

//--- tb/spi_slave_tx_dma_config_tb.sv
// testbench: registers, buffer fetch and serial frames of the slave transmit block
`timescale 1ns/1ps
`default_nettype none
module spi_slave_tx_dma_config_tb;
   import sstx_pkg::*;
   localparam logic [11:0] OFFS [7] = '{SSTX_OFF_TX_ADDR, SSTX_OFF_TX_SIZE, SSTX_OFF_TX_SENT,
      SSTX_OFF_LIST, SSTX_OFF_CONFIG, SSTX_OFF_IGN_CHAR, SSTX_OFF_OVR_CHAR};
   localparam logic [31:0] MSK [7] = '{32'hFFFFFFFF, 32'h1FFF, 32'h0, 32'h1, 32'h7,
      32'hFF, 32'hFF};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [31:0] wb_adr = 32'h0;
   logic [31:0] wb_dw = 32'h0;
   logic [31:0] wb_dr;
   logic        wb_we = 1'b0;
   logic [3:0]  wb_sel = 4'h0;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_ack;
   logic        mem_req;
   logic [31:0] mem_addr;
   logic        mem_ack = 1'b0;
   logic [31:0] mem_rdata = 32'h0;
   logic        sck, csn, miso, miso_oe_n, frame_done;
   logic        cpol = 1'b0;
   logic        cpha = 1'b0;
   logic [31:0] ptr_v = 32'h0;
   int          size_v, bad_count, checks_done, fetch_n, fetch_bad, done_n, wcnt;

   sstx_core dut_u (.clk(clk), .rst(rst), .wb_adr_i(wb_adr), .wb_dat_i(wb_dw),
      .wb_dat_o(wb_dr), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .sck(sck), .csn(csn), .miso_o(miso),
      .miso_oe_n(miso_oe_n), .frame_done(frame_done));
   sstx_spi_master spi_u (.clk(clk), .cpol(cpol), .cpha(cpha), .sck(sck), .csn(csn),
      .miso_o(miso), .miso_oe_n(miso_oe_n));

   // ----------------------------------------
   // memory model and event counters
   // ----------------------------------------
   function automatic logic [7:0] mbyte(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction
   function automatic logic [7:0] rev8(input logic [7:0] v);
      return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
   endfunction
   always @(posedge clk) begin
      mem_ack <= 1'b0;
      wcnt <= 0;
      if (mem_req === 1'b1 && mem_ack === 1'b0) begin
         wcnt <= wcnt + 1;
         if (wcnt >= int'(mem_addr[3:2])) begin
            mem_ack <= 1'b1;
            mem_rdata <= {mbyte(mem_addr + 32'h3), mbyte(mem_addr + 32'h2),
               mbyte(mem_addr + 32'h1), mbyte(mem_addr)};
            fetch_n <= fetch_n + 1;
            if (mem_addr + 32'h4 <= ptr_v || mem_addr >= ptr_v + 32'(size_v)
                || mem_addr[1:0] != 2'b00)
               fetch_bad <= fetch_bad + 1;
         end
      end
   end
   always @(posedge clk)
      if (frame_done === 1'b1)
         done_n <= done_n + 1;

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (bad_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_sel <= 4'hF;
      wb_adr <= {20'h0, a};
      wb_dw <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 40);
      q = wb_dr;
      if (wb_ack !== 1'b1) begin
         bad_count++;
         print_verdict();
      end
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic run(input int nb, input logic gr, input logic [2:0] c,
                      input logic [7:0] ign, input logic [7:0] ovr, inout int sent);
      int f0, d0;
      logic [7:0] e;
      logic [31:0] q;
      f0 = fetch_n;
      d0 = done_n;
      spi_u.rx_q.delete();
      if (gr)
         wb(1'b1, SSTX_OFF_CTRL, 32'h1, q);
      spi_u.frame(nb);
      for (int i = 0; i < nb; i++) begin
         e = !gr ? ign : (i > size_v ? ovr : mbyte(ptr_v + 32'(i) - 32'h1));
         if (c[0])
            e = rev8(e);
         if (i > 0 || !gr)
            check(32'(spi_u.rx_q[i]), 32'(e));
      end
      if (gr)
         sent = (nb - 1 < size_v) ? nb - 1 : size_v;
      wb(1'b0, SSTX_OFF_TX_SENT, 32'h0, q);
      check(q, 32'(sent));
      check(32'(done_n - d0), gr ? 32'h1 : 32'h0);
      check(32'(fetch_n - f0 <= size_v), 32'h1);
      check(32'(fetch_bad), 32'h0);
      check(32'(spi_u.oe_err), 32'h0);
      check({31'h0, miso_oe_n}, 32'h1);
   endtask

   // ----------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------
   initial
      forever #2 clk = ~clk;
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
   initial begin
      logic [31:0] q, v;
      logic [7:0] ign, ovr;
      int sent, nb;
      void'($urandom(46869));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (OFFS[i]) begin
         wb(1'b0, OFFS[i], 32'h0, q);
         check(q, SSTX_RST_WORD);
      end
      wb(1'b1, 12'h700, 32'hFFFFFFFF, q);
      wb(1'b0, 12'h700, 32'h0, q);
      check(q, 32'h0);
      foreach (OFFS[i]) begin
         v = $urandom;
         wb(1'b1, OFFS[i], v, q);
         wb(1'b0, OFFS[i], 32'h0, q);
         check(q, v & MSK[i]);
      end
      wb(1'b1, SSTX_OFF_TX_SIZE, 32'h0000FFFF, q);
      wb(1'b0, SSTX_OFF_TX_SIZE, 32'h0, q);
      check(q, {19'h0, SSTX_CNT_MAX});
      sent = 0;
      for (int c = 0; c < 8; c++) begin
         ign = 8'($urandom);
         ovr = 8'($urandom);
         ptr_v = 32'h20000000 | ($urandom & 32'hFFFF);
         size_v = (c == 0) ? 1 : $urandom_range(4, 1);
         nb = $urandom_range(size_v + 3, 2);
         cpol <= c[2];
         cpha <= c[1];
         wb(1'b1, SSTX_OFF_CONFIG, 32'(c), q);
         wb(1'b1, SSTX_OFF_IGN_CHAR, 32'(ign), q);
         wb(1'b1, SSTX_OFF_OVR_CHAR, 32'(ovr), q);
         wb(1'b1, SSTX_OFF_TX_ADDR, ptr_v, q);
         wb(1'b1, SSTX_OFF_TX_SIZE, 32'(size_v), q);
         run(3, 1'b0, 3'(c), ign, ovr, sent);
         run(nb, 1'b1, 3'(c), ign, ovr, sent);
      end
      print_verdict();
   end
endmodule // spi_slave_tx_dma_config_tb
`default_nettype wire
